// ==== src/supervisor_pkg.sv ====
// Purpose: shared constants and types of the supply supervisor pair
// Assumes: one 50 MHz clock on both ends
// Notes:   timing counts are derived from the printed times
`default_nettype none
package supervisor_pkg;
    // Clock and timebase
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
    // Nominal watchdog period and power-on reset delay
    localparam int unsigned WDOG_PERIOD_MS = 800;
    localparam int unsigned WDOG_CYCLES = WDOG_PERIOD_MS * CLK_PER_MS;
    localparam int unsigned RST_DELAY_MS = 100;
    localparam int unsigned RST_CYCLES = RST_DELAY_MS * CLK_PER_MS;
    // Internal kick pulse: least width, rounded up to whole cycles
    localparam int unsigned KICK_PULSE_NS = 100;
    localparam int unsigned KICK_PULSE_CYC =
        (KICK_PULSE_NS * CLK_PER_US + 999) / 1000;
    // Pulse position inside the period, as a fraction
    localparam int unsigned KICK_AT_NUM = 7;
    localparam int unsigned KICK_AT_DEN = 8;
    localparam int unsigned CNT_W = 26;

    // Comparator result vector, bit positions
    localparam int unsigned CMP_RESET = 0;
    localparam int unsigned CMP_LOWLINE = 1;
    localparam int unsigned CMP_BATTERY = 2;
    localparam int unsigned CMP_AUX = 3;
    localparam int unsigned CMP_AUX_HYS = 4;
    localparam int unsigned NCMP = 5;

    // Supply source selection
    typedef enum logic {SRC_MAIN, SRC_BATTERY} src_t;

    // Host register map, byte addresses
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_LEVEL = 8'h0c;
    localparam logic [7:0] OFS_KICK = 8'h10;
    // Control fields
    localparam int unsigned CTRL_FORCE = 0;
    localparam int unsigned CTRL_KICK_OE = 1;
    localparam int unsigned CTRL_W = 2;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int unsigned KICK_LEVEL = 0;
    // Event and level bits (status, mask and level share this layout)
    localparam int unsigned EV_RESET = 0;
    localparam int unsigned EV_WARN = 1;
    localparam int unsigned EV_AUX = 2;
    localparam int unsigned EV_BACKUP = 3;
    localparam int unsigned NEV = 4;
    localparam logic [3:0] EV_RST = 4'h0;
endpackage
`default_nettype wire

// ==== src/supervisor_if.sv ====
// Purpose: pins between the supervisor and its host processor
// Assumes: both ends on pclk
// Notes:   kick wire resolved here; host drive beats the weak pull
`default_nettype none
interface supervisor_if;
    logic sup_reset_n;
    logic early_warn_n;
    logic aux_fail_flag;
    logic backup_active_flag;
    logic force_backup_input;
    logic kick_host_out;
    logic kick_host_oe;
    logic kick_dev_out;
    logic kick_dev_oe;
    logic watchdog_kick_input;

    // Wire level: host strong, device weak, else low
    assign watchdog_kick_input = kick_host_oe ? kick_host_out :
                                 kick_dev_oe ? kick_dev_out : 1'b0;

    modport dev (
        output sup_reset_n, early_warn_n, aux_fail_flag,
        output backup_active_flag, kick_dev_out, kick_dev_oe,
        input force_backup_input, watchdog_kick_input
    );
    modport host (
        input sup_reset_n, early_warn_n, aux_fail_flag,
        input backup_active_flag, watchdog_kick_input,
        output force_backup_input, kick_host_out, kick_host_oe
    );
endinterface
`default_nettype wire

// ==== src/supply_supervisor.sv ====
// Purpose: supervisor end: reset, low-line, aux flag, switchover, dog
// Assumes: comparator results arrive as asynchronous levels
// Notes:   all outputs but kick_dev_oe come from flip-flops of one state struct; kick_dev_oe is tied high
`default_nettype none

module supply_supervisor
    import supervisor_pkg::*;
#(
    parameter int unsigned WD_CYCLES = WDOG_CYCLES,
    parameter int unsigned RST_DLY_CYCLES = RST_CYCLES,
    parameter int unsigned PULSE_CYCLES = KICK_PULSE_CYC,
    parameter int unsigned CNT_WIDTH = CNT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    supervisor_if.dev link,
    input wire logic vdd_above_reset,
    input wire logic vdd_above_lowline,
    input wire logic vdd_above_battery,
    input wire logic aux_above_thr,
    input wire logic aux_above_hys
);
    // Position of the internal kick pulse within the period
    // Whole eighths first, so the pulse never lands past 7/8
    localparam int unsigned PULSE_AT =
        WD_CYCLES / KICK_AT_DEN * KICK_AT_NUM;
    localparam logic [CNT_WIDTH-1:0] WD_LAST =
        CNT_WIDTH'(WD_CYCLES - 1);
    localparam logic [CNT_WIDTH-1:0] RST_DONE =
        CNT_WIDTH'(RST_DLY_CYCLES);
    localparam logic [CNT_WIDTH-1:0] PULSE_LO = CNT_WIDTH'(PULSE_AT);
    localparam logic [CNT_WIDTH-1:0] PULSE_HI =
        CNT_WIDTH'(PULSE_AT + PULSE_CYCLES);

    // Refuse counts the counters cannot hold
    if (CNT_WIDTH > 31 || WD_CYCLES < 16 || RST_DLY_CYCLES < 1 ||
        PULSE_CYCLES < 1 ||
        WD_CYCLES >= (32'h1 << CNT_WIDTH) ||
        RST_DLY_CYCLES >= (32'h1 << CNT_WIDTH) ||
        PULSE_AT + PULSE_CYCLES >= WD_CYCLES) begin : g_bad_params
        $error("supply_supervisor: unsupported count parameters");
    end

    typedef struct packed {
        logic [NCMP-1:0] cmp_s1;
        logic [NCMP-1:0] cmp_s2;
        logic force_s1;
        logic force_s2;
        logic kick_s1;
        logic kick_s2;
        logic kick_s3;
        logic [1:0] fill;
        src_t src;
        logic forced;
        logic aux_ok;
        logic warn_n;
        logic batt_on;
        logic [CNT_WIDTH-1:0] rst_cnt;
        logic rst_n;
        logic [CNT_WIDTH-1:0] wd_cnt;
        logic kick_drv;
    } dev_state_t;

    dev_state_t q;
    dev_state_t d;
    logic [NCMP-1:0] cmp_raw;
    logic above_rst;
    logic above_ll;
    logic above_bat;
    logic force_in;
    logic kick_edge;
    logic wd_timeout;
    logic sync_full;

    // Raw comparator results in vector order
    assign cmp_raw[CMP_RESET] = vdd_above_reset;
    assign cmp_raw[CMP_LOWLINE] = vdd_above_lowline;
    assign cmp_raw[CMP_BATTERY] = vdd_above_battery;
    assign cmp_raw[CMP_AUX] = aux_above_thr;
    assign cmp_raw[CMP_AUX_HYS] = aux_above_hys;

    // Synchronised views; only second stages feed logic
    assign above_rst = q.cmp_s2[CMP_RESET];
    assign above_ll = q.cmp_s2[CMP_LOWLINE];
    assign above_bat = q.cmp_s2[CMP_BATTERY];
    assign force_in = q.force_s2;
    // Third stage only remembers the previous level
    // Either direction counts as a kick
    assign kick_edge = q.kick_s2 ^ q.kick_s3;
    // Expiry only counts while reset is released
    assign wd_timeout = q.rst_n && (q.wd_cnt == WD_LAST);
    // Pipe fill flag: reset zeros in the synchronisers read as a dead
    // supply, which would flick the source to battery for two cycles
    assign sync_full = q.fill[1];

    // Next-state logic for the whole supervisor
    always_comb begin
        d = q;
        // Two-stage synchronisers for all pins
        // Host pins get them too, so latency matches a real board
        d.cmp_s1 = cmp_raw;
        d.cmp_s2 = q.cmp_s1;
        d.force_s1 = link.force_backup_input;
        d.force_s2 = q.force_s1;
        d.kick_s1 = link.watchdog_kick_input;
        d.kick_s2 = q.kick_s1;
        d.kick_s3 = q.kick_s2;
        // Ones shift in behind reset, marking a full pipe
        d.fill = {q.fill[0], 1'b1};

        // Aux flag: drop at threshold, recover only past hysteresis
        // In between the flag holds, which is the hysteresis band
        if (!q.cmp_s2[CMP_AUX]) begin
            d.aux_ok = 1'b0;
        end else if (q.cmp_s2[CMP_AUX_HYS]) begin
            d.aux_ok = 1'b1;
        end

        // Early warning follows the low-line comparator
        d.warn_n = above_ll;

        // Source selection
        unique case (q.src)
            SRC_MAIN: begin
                if (force_in) begin
                    d.src = SRC_BATTERY;
                    d.forced = 1'b1;
                end else if (sync_full && !above_rst && !above_bat) begin
                    // Battery above supply is not enough on its own;
                    // a pipe still full of reset zeros is no failure
                    d.src = SRC_BATTERY;
                end
            end
            SRC_BATTERY: begin
                // A forced hold ends only with a real supply failure
                if (!above_rst) begin
                    d.forced = 1'b0;
                end
                if (!q.forced && (above_rst || above_bat)) begin
                    d.src = SRC_MAIN;
                end
            end
        endcase
        // Flag taken from the same next state, so never skews
        d.batt_on = (d.src == SRC_BATTERY);

        // Reset delay: restarts on supply dip or watchdog expiry
        if (!above_rst || wd_timeout) begin
            d.rst_cnt = '0;
        end else if (q.rst_cnt != RST_DONE) begin
            d.rst_cnt = q.rst_cnt + 1'b1;
        end
        // Compare the next count so release is not a cycle late
        d.rst_n = (d.rst_cnt == RST_DONE);

        // Watchdog period, idle while reset is active
        // A host driving the pin must kick well inside the period
        if (!q.rst_n || kick_edge || wd_timeout) begin
            d.wd_cnt = '0;
        end else begin
            d.wd_cnt = q.wd_cnt + 1'b1;
        end

        // Weak low, then a short high late in the period. A floating
        // pin follows this pulse and the edge restarts the count;
        // a host driving the pin hides it.
        d.kick_drv = (d.wd_cnt >= PULSE_LO) &&
            (d.wd_cnt < PULSE_HI);
    end

    // State register; every field resets to a constant
    // Fill flag clears with it, so the pipe guard rearms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Pin drivers straight from flip-flops, except the constant kick enable
    // No decode after the register, so pins never glitch
    assign link.sup_reset_n = q.rst_n;
    assign link.early_warn_n = q.warn_n;
    assign link.aux_fail_flag = q.aux_ok;
    assign link.backup_active_flag = q.batt_on;
    assign link.kick_dev_out = q.kick_drv;
    // Weak drive stays on; the interface lets the host override it
    assign link.kick_dev_oe = 1'b1;
endmodule
`default_nettype wire

// ==== src/supervisor_host.sv ====
// Purpose: host end: APB registers driving force and kick pins
// Assumes: zero-wait APB slave on pclk
// Notes:   sticky events raise one level interrupt
`default_nettype none
module supervisor_host
    import supervisor_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    supervisor_if.host link
);
    typedef struct packed {
        logic [NEV-1:0] pin_s1;
        logic [NEV-1:0] pin_s2;
        logic [NEV-1:0] pin_s3;
        logic [CTRL_W-1:0] ctrl;
        logic [NEV-1:0] status;
        logic [NEV-1:0] mask;
        logic kick_lvl;
        logic [31:0] rdata;
        logic err;
        logic irq;
    } host_state_t;

    host_state_t q;
    host_state_t d;
    logic [NEV-1:0] pins;
    logic [NEV-1:0] events;
    logic [NEV-1:0] clr;
    logic wr;
    logic setup;

    // Supervisor pins in level-register order
    assign pins[EV_RESET] = link.sup_reset_n;
    assign pins[EV_WARN] = link.early_warn_n;
    assign pins[EV_AUX] = link.aux_fail_flag;
    assign pins[EV_BACKUP] = link.backup_active_flag;

    // Falling reset, warning and aux; rising backup flag
    assign events[EV_RESET] = q.pin_s3[EV_RESET] & ~q.pin_s2[EV_RESET];
    assign events[EV_WARN] = q.pin_s3[EV_WARN] & ~q.pin_s2[EV_WARN];
    assign events[EV_AUX] = q.pin_s3[EV_AUX] & ~q.pin_s2[EV_AUX];
    assign events[EV_BACKUP] =
        q.pin_s2[EV_BACKUP] & ~q.pin_s3[EV_BACKUP];

    // Writes land at the access edge, reads sampled in setup
    assign wr = psel && penable && pwrite;
    assign setup = psel && !penable;
    assign clr = (wr && paddr == OFS_STATUS) ? pwdata[NEV-1:0] : EV_RST;

    // Register file and event logic
    always_comb begin
        d = q;
        d.pin_s1 = pins;
        d.pin_s2 = q.pin_s1;
        d.pin_s3 = q.pin_s2;
        if (wr) begin
            unique case (paddr)
                OFS_CTRL: d.ctrl = pwdata[CTRL_W-1:0];
                OFS_MASK: d.mask = pwdata[NEV-1:0];
                OFS_KICK: d.kick_lvl = pwdata[KICK_LEVEL];
                default: d.ctrl = q.ctrl;
            endcase
        end
        // Set beats a same-cycle clear
        d.status = (q.status & ~clr) | events;
        d.irq = |(d.status & d.mask);
        if (setup) begin
            d.err = 1'b0;
            unique case (paddr)
                OFS_CTRL: d.rdata = {30'h0, q.ctrl};
                OFS_STATUS: d.rdata = {28'h0, q.status};
                OFS_MASK: d.rdata = {28'h0, q.mask};
                OFS_LEVEL: d.rdata = {28'h0, q.pin_s2};
                OFS_KICK: d.rdata = {31'h0, q.kick_lvl};
                default: begin
                    d.rdata = 32'h0;
                    d.err = 1'b1;
                end
            endcase
        end
    end

    // Force stays low from reset until software sets it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pslverr = q.err;
    // Every access completes in its first access cycle
    assign pready = 1'b1;
    assign irq = q.irq;
    assign link.force_backup_input = q.ctrl[CTRL_FORCE];
    // Kick pin released after reset, so the internal pulse keeps the watchdog fed
    assign link.kick_host_out = q.kick_lvl;
    assign link.kick_host_oe = q.ctrl[CTRL_KICK_OE];
endmodule
`default_nettype wire

// ==== bench/supervisor_monitor.sv ====
// Purpose: pin checks between the supervisor and its host
// Assumes: one clock; outputs lag comparator inputs by three edges
// Notes:   quiet_q counts cycles since the last kick-pin edge or reset release, held at 0 while reset is low
`default_nettype none
module supervisor_monitor
    import supervisor_pkg::*;
#(
    parameter int unsigned WD_CYCLES = 64,
    parameter int unsigned RST_DLY_CYCLES = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sup_reset_n,
    input wire logic early_warn_n,
    input wire logic aux_fail_flag,
    input wire logic backup_active_flag,
    input wire logic force_backup_input,
    input wire logic watchdog_kick_input,
    input wire logic kick_dev_out,
    input wire logic [NCMP-1:0] cmp
);
    localparam int P_LO = WD_CYCLES / 8 * 7;
    localparam int P_HI = P_LO + 6;
    localparam int WD_MAX = WD_CYCLES + 8;
    localparam int R_MAX = RST_DLY_CYCLES + 6;
    logic [2:0] up_q;
    logic [5:0] frc_q;
    logic kick_q;
    int quiet_q;
    int lo_q;
    // Force history: its path latency into the device is not pinned down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_q <= 3'h0;
            frc_q <= 6'h00;
            kick_q <= 1'b0;
            quiet_q <= 0;
            lo_q <= 0;
        end else begin
            up_q <= up_q[2] ? up_q : up_q + 3'h1;
            frc_q <= {frc_q[4:0], force_backup_input};
            kick_q <= watchdog_kick_input;
            quiet_q <= (!sup_reset_n || watchdog_kick_input != kick_q) ?
                0 : quiet_q + 1;
            lo_q <= (sup_reset_n || !cmp[CMP_RESET]) ? 0 : lo_q + 1;
        end
    end
    // Quiet until the sync pipe holds post-reset values
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !up_q[2]);
    chk_warn_level: assert property (
        early_warn_n == $past(cmp[CMP_LOWLINE], 3))
        else $error("warning does not follow low-line input");
    chk_aux_fall: assert property (
        !$past(cmp[CMP_AUX], 3) |-> !aux_fail_flag)
        else $error("aux flag high below threshold");
    chk_aux_rise: assert property (
        $rose(aux_fail_flag) |-> $past(cmp[CMP_AUX_HYS], 3))
        else $error("aux flag rose inside hysteresis");
    chk_batt_auto: assert property (
        !$past(cmp[CMP_RESET], 3) && !$past(cmp[CMP_BATTERY], 3)
        |-> backup_active_flag)
        else $error("battery not selected on supply failure");
    chk_batt_enter: assert property (
        $rose(backup_active_flag) |-> frc_q != 6'h00 ||
        (!$past(cmp[CMP_RESET], 3) && !$past(cmp[CMP_BATTERY], 3)))
        else $error("battery selected without cause");
    chk_batt_leave: assert property (
        $fell(backup_active_flag) |->
        $past(cmp[CMP_RESET], 3) || $past(cmp[CMP_BATTERY], 3))
        else $error("battery left while supply still low");
    chk_rst_low: assert property (
        !$past(cmp[CMP_RESET], 3) |-> !sup_reset_n)
        else $error("reset released below threshold");
    chk_rst_delay: assert property (
        $rose(sup_reset_n) |-> lo_q >= RST_DLY_CYCLES)
        else $error("reset released before its delay");
    chk_rst_bound: assert property (
        lo_q <= R_MAX)
        else $error("reset held too long");
    chk_wd_expire: assert property (
        sup_reset_n |-> quiet_q < WD_MAX)
        else $error("watchdog did not expire");
    chk_wd_kicked: assert property (
        $fell(sup_reset_n) && $past(cmp[CMP_RESET], 3)
        |-> quiet_q >= WD_CYCLES)
        else $error("watchdog fired although kicked");
    chk_pulse_pos: assert property (
        sup_reset_n && $rose(kick_dev_out)
        |-> quiet_q >= P_LO && quiet_q <= P_HI)
        else $error("internal kick pulse misplaced");
    chk_pulse_len: assert property (
        $rose(kick_dev_out) |-> ##2 !kick_dev_out)
        else $error("internal kick pulse too long");
    cover property ($rose(backup_active_flag));
    cover property ($fell(sup_reset_n) && cmp[CMP_RESET]);
    cover property (sup_reset_n && $rose(kick_dev_out));
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench for the supervisor and host pair
// Assumes: shortened watchdog and reset delay counts
// Notes:   random comparator levels mixed with fixed corner cases
`default_nettype none
module tb_top
    import supervisor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WD = 64;
    localparam int unsigned RD = 20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, se;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic [NCMP-1:0] cmp;
    logic e_aux;
    int err_total, checked, seed, n;
    supervisor_if supervisor_if_i ();
    wire logic srst_n = supervisor_if_i.sup_reset_n;
    wire logic batt = supervisor_if_i.backup_active_flag;
    supply_supervisor #(.WD_CYCLES(WD), .RST_DLY_CYCLES(RD),
        .PULSE_CYCLES(2), .CNT_WIDTH(CNT_W)) supply_supervisor_i (
        .pclk(pclk), .presetn(presetn), .link(supervisor_if_i.dev),
        .vdd_above_reset(cmp[CMP_RESET]),
        .vdd_above_lowline(cmp[CMP_LOWLINE]),
        .vdd_above_battery(cmp[CMP_BATTERY]),
        .aux_above_thr(cmp[CMP_AUX]), .aux_above_hys(cmp[CMP_AUX_HYS]));
    supervisor_host supervisor_host_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .link(supervisor_if_i.host));
    supervisor_monitor #(.WD_CYCLES(WD), .RST_DLY_CYCLES(RD))
        supervisor_monitor_i (
        .pclk(pclk), .presetn(presetn), .sup_reset_n(srst_n),
        .early_warn_n(supervisor_if_i.early_warn_n),
        .aux_fail_flag(supervisor_if_i.aux_fail_flag),
        .backup_active_flag(batt),
        .force_backup_input(supervisor_if_i.force_backup_input),
        .watchdog_kick_input(supervisor_if_i.watchdog_kick_input),
        .kick_dev_out(supervisor_if_i.kick_dev_out), .cmp(cmp));
    // Free-running 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Step past the edge so its updates have landed
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            err_total++;
            end_of_test();
        end
    endtask
    // Bounded wait for the reset pin; n returns the cycles taken
    task automatic wait_rst(input logic v);
        for (n = 0; n < 400 && srst_n !== v; n++) cyc(1);
        if (n >= 400) begin
            err_total++;
            end_of_test();
        end
    endtask
    function automatic logic exp_batt(input logic [NCMP-1:0] c);
        return !(c[CMP_RESET] | c[CMP_BATTERY]);
    endfunction
    function automatic logic exp_aux(input logic p, input logic [4:0] c);
        return !c[CMP_AUX] ? 1'b0 : (c[CMP_AUX_HYS] ? 1'b1 : p);
    endfunction
    initial begin
        logic [7:0] offs [4];
        offs = '{OFS_CTRL, OFS_STATUS, OFS_MASK, 8'h20};
        seed = 79;
        err_total = 0;
        checked = 0;
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = '0;
        pwdata = '0;
        cmp = '1;
        e_aux = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then an unmapped word
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, offs[i], 32'h0);
            chk(rd, 32'h0);
            chk(se, i == 3);
        end
        chk(srst_n, 1'b0);
        wait_rst(1'b1);
        // Level word mirrors the settled pins once host sync has caught up
        cyc(2);
        apb(1'b0, OFS_LEVEL, 32'h0);
        chk(rd, 32'h7);
        $display("test power-up done");
        // Low-line event: sticky, maskable, write-one-to-clear
        apb(1'b1, OFS_MASK, 32'hf);
        @(posedge pclk);
        cmp[CMP_LOWLINE] <= 1'b0;
        cyc(6);
        chk(supervisor_if_i.early_warn_n, 1'b0);
        chk(irq, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h1 << EV_WARN);
        apb(1'b1, OFS_MASK, 32'h0);
        cyc(2);
        chk(irq, 1'b0);
        apb(1'b1, OFS_STATUS, 32'h1 << EV_WARN);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        @(posedge pclk);
        cmp[CMP_LOWLINE] <= 1'b1;
        $display("test interrupt done");
        // Forced battery mode outlives the force input
        apb(1'b1, OFS_CTRL, 32'h1);
        cyc(6);
        chk(batt, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0);
        cyc(6);
        chk(batt, 1'b1);
        @(posedge pclk);
        cmp[CMP_RESET] <= 1'b0;
        cyc(6);
        chk(batt, 1'b0);
        $display("test force done");
        // Random comparator levels
        for (int i = 0; i < 200; i++) begin
            r = $random(seed);
            @(posedge pclk);
            cmp <= r[NCMP-1:0];
            e_aux = exp_aux(e_aux, r[NCMP-1:0]);
            cyc(5);
            chk(batt, exp_batt(r[NCMP-1:0]));
            chk(supervisor_if_i.early_warn_n, r[CMP_LOWLINE]);
            chk(supervisor_if_i.aux_fail_flag, e_aux);
            if (!r[CMP_RESET]) chk(srst_n, 1'b0);
        end
        $display("test random done");
        // Floating kick pin never times out; aux input grounded
        @(posedge pclk);
        cmp <= NCMP'(~((32'h1 << CMP_AUX) | (32'h1 << CMP_AUX_HYS)));
        wait_rst(1'b1);
        n = 0;
        repeat (4 * WD) begin
            cyc(1);
            if (srst_n !== 1'b1) n++;
        end
        chk(n, 0);
        chk(supervisor_if_i.aux_fail_flag, 1'b0);
        // Host toggles at random spacing, then goes silent
        apb(1'b1, OFS_CTRL, 32'h2);
        for (int i = 0; i < 12; i++) begin
            // Low-high-low pulse, then a random quiet gap
            apb(1'b1, OFS_KICK, 32'h1);
            apb(1'b1, OFS_KICK, 32'h0);
            cyc(8 + ($unsigned($random(seed)) % 24));
            chk(srst_n, 1'b1);
        end
        wait_rst(1'b0);
        chk(n > WD - 40 && n < WD + 8, 1'b1);
        wait_rst(1'b1);
        chk(n >= RD, 1'b1);
        $display("test watchdog done");
        end_of_test();
    end
endmodule
`default_nettype wire
